// ===== common/asttm_params.svh
// Offsets, reset values and timing counts of the self-test timing block.
`ifndef ASTTM_PARAMS_SVH
`define ASTTM_PARAMS_SVH
`define ASTTM_IDLE_CFG_ADDR 8'h37
`define ASTTM_DEC_CFG_ADDR 8'h38
`define ASTTM_CTRL_ADDR 8'h39
`define ASTTM_STATUS_ADDR 8'h3A
`define ASTTM_IDLE_RST 8'h00
`define ASTTM_DEC_RST 8'h00
`define ASTTM_CTRL_RST 8'h00
`define ASTTM_CLK_MHZ 25
`define ASTTM_IDLE_BASE_NS 312500
`define ASTTM_IDLE_STEP_NS 31250
`define ASTTM_IDLE_BASE_CYC (`ASTTM_IDLE_BASE_NS * `ASTTM_CLK_MHZ / 1000)
`define ASTTM_IDLE_STEP_CYC (`ASTTM_IDLE_STEP_NS * `ASTTM_CLK_MHZ / 1000)
`define ASTTM_DEC_MAX 4'hC
`endif

// ===== common/asttm_pkg.sv
// Types shared by the self-test timing block.
package asttm_pkg;
    typedef enum logic [1:0] {ASTTM_OFF, ASTTM_IDLE, ASTTM_MEAS} asttm_state_e;
endpackage

// ===== verilog/asttm_top.sv
// Self-test idle phase timer with a measurement-done strobe and its Wishbone registers.
`timescale 1ns/100ps
`default_nettype none
`include "asttm_params.svh"
module asttm_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [1:0] user_output_data_rate_i,
    input wire logic user_power_mode_i,
    output logic [1:0] eff_output_data_rate_o,
    output logic eff_power_mode_o,
    output logic selftest_active_o,
    output logic idle_phase_o,
    output logic meas_done_o
);
    logic [4:0] idle_code_q, idle_code_d;
    logic [3:0] dec_code_q, dec_code_d;
    logic [1:0] axis_sel_q, axis_sel_d;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d;
    asttm_pkg::asttm_state_e st_q, st_d;
    logic [4:0] run_idle_q, run_idle_d;
    logic [3:0] run_dec_q, run_dec_d;
    logic [15:0] cyc_q, cyc_d;
    logic [12:0] smp_q, smp_d;
    logic done_q, done_d;
    logic [1:0] odr_q, odr_d;
    logic pm_q, pm_d;
    logic act_q, act_d;
    logic idle_ph_q, idle_ph_d;
    logic [15:0] idle_len;
    logic [12:0] smp_len;
    logic wr;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
    assign idle_len = 16'(`ASTTM_IDLE_BASE_CYC)
        + 16'(`ASTTM_IDLE_STEP_CYC) * {11'h000, run_idle_q};
    // Clamping codes above twelve keeps the sample counter in 13 bits.
    assign smp_len = (run_dec_q > `ASTTM_DEC_MAX) ? 13'h1000
        : 13'(13'h0001 << run_dec_q);

    always_comb begin
        idle_code_d = idle_code_q;
        dec_code_d = dec_code_q;
        axis_sel_d = axis_sel_q;
        dat_d = 32'h00000000;
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        if (wr) begin
            case (wb_adr_i)
                `ASTTM_IDLE_CFG_ADDR: idle_code_d = wb_dat_i[4:0];
                `ASTTM_DEC_CFG_ADDR: dec_code_d = wb_dat_i[3:0];
                `ASTTM_CTRL_ADDR: axis_sel_d = wb_dat_i[1:0];
                default: ;
            endcase
        end
        case (wb_adr_i)
            `ASTTM_IDLE_CFG_ADDR: dat_d = {27'h0000000, idle_code_q};
            `ASTTM_DEC_CFG_ADDR: dat_d = {28'h0000000, dec_code_q};
            `ASTTM_CTRL_ADDR: dat_d = {30'h00000000, axis_sel_q};
            `ASTTM_STATUS_ADDR: dat_d = {24'h000000, run_dec_q, 1'b0,
                st_q == asttm_pkg::ASTTM_MEAS, st_q == asttm_pkg::ASTTM_IDLE,
                st_q != asttm_pkg::ASTTM_OFF};
            default: dat_d = 32'h00000000;
        endcase
    end

    always_comb begin
        st_d = st_q;
        run_idle_d = run_idle_q;
        run_dec_d = run_dec_q;
        cyc_d = cyc_q;
        smp_d = smp_q;
        done_d = 1'b0;
        case (st_q)
            asttm_pkg::ASTTM_OFF: begin
                if (axis_sel_q != 2'h0) begin
                    st_d = asttm_pkg::ASTTM_IDLE;
                    run_idle_d = idle_code_q;
                    run_dec_d = dec_code_q;
                    cyc_d = 16'h0000;
                    smp_d = 13'h0000;
                end
            end
            asttm_pkg::ASTTM_IDLE: begin
                // Each sample takes one idle duration, so the period is
                // samples times idle length.
                if (cyc_q + 16'h0001 >= idle_len) begin
                    cyc_d = 16'h0000;
                    if (smp_q + 13'h0001 >= smp_len) begin
                        done_d = 1'b1;
                        smp_d = 13'h0000;
                        run_idle_d = idle_code_q;
                        run_dec_d = dec_code_q;
                    end else begin
                        smp_d = smp_q + 13'h0001;
                    end
                end else begin
                    cyc_d = cyc_q + 16'h0001;
                end
                st_d = asttm_pkg::ASTTM_IDLE;
            end
            default: st_d = asttm_pkg::ASTTM_OFF;
        endcase
        if (axis_sel_q == 2'h0) begin
            st_d = asttm_pkg::ASTTM_OFF;
        end
    end

    // The outputs follow the next state, so the forced rate, the active
    // flag and the idle flag all change on the same edge as the state.
    always_comb begin
        act_d = (st_d != asttm_pkg::ASTTM_OFF);
        idle_ph_d = (st_d == asttm_pkg::ASTTM_IDLE);
        if (st_d == asttm_pkg::ASTTM_OFF) begin
            odr_d = user_output_data_rate_i;
            pm_d = user_power_mode_i;
        end else begin
            odr_d = 2'h0;
            pm_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idle_code_q <= 5'(`ASTTM_IDLE_RST);
            dec_code_q <= 4'(`ASTTM_DEC_RST);
            axis_sel_q <= 2'(`ASTTM_CTRL_RST);
        end else begin
            idle_code_q <= idle_code_d;
            dec_code_q <= dec_code_d;
            axis_sel_q <= axis_sel_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h00000000;
            ack_q <= 1'b0;
        end else begin
            dat_q <= dat_d;
            ack_q <= ack_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= asttm_pkg::ASTTM_OFF;
            run_idle_q <= 5'h00;
            run_dec_q <= 4'h0;
            cyc_q <= 16'h0000;
            smp_q <= 13'h0000;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            run_idle_q <= run_idle_d;
            run_dec_q <= run_dec_d;
            cyc_q <= cyc_d;
            smp_q <= smp_d;
            done_q <= done_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            odr_q <= 2'h0;
            pm_q <= 1'b0;
            act_q <= 1'b0;
            idle_ph_q <= 1'b0;
        end else begin
            odr_q <= odr_d;
            pm_q <= pm_d;
            act_q <= act_d;
            idle_ph_q <= idle_ph_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign eff_output_data_rate_o = odr_q;
    assign eff_power_mode_o = pm_q;
    assign selftest_active_o = act_q;
    assign idle_phase_o = idle_ph_q;
    assign meas_done_o = done_q;

    a_idle_len_fix: assert property (
        @(posedge clk_i) disable iff (rst_i)
        idle_len == 16'h1E84 + 16'h030D * {11'h000, run_idle_q})
        else $error("idle length wrong");

    a_cyc_bound: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cyc_q < idle_len)
        else $error("idle counter past its length");

    a_dec_clamp: assert property (
        @(posedge clk_i) disable iff (rst_i)
        run_dec_q >= 4'hC |-> smp_len == 13'h1000)
        else $error("decimation clamp wrong");

    a_dec_pow: assert property (
        @(posedge clk_i) disable iff (rst_i)
        run_dec_q < 4'hC |-> smp_len == 13'(13'h0001 << run_dec_q))
        else $error("decimation count wrong");

    a_smp_bound: assert property (
        @(posedge clk_i) disable iff (rst_i)
        smp_q < smp_len)
        else $error("sample counter past its length");

    a_user_block: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_q != asttm_pkg::ASTTM_OFF |-> odr_q == 2'h0 && !pm_q)
        else $error("user rate leaked");

    a_active_out: assert property (
        @(posedge clk_i) disable iff (rst_i)
        act_q == (st_q != asttm_pkg::ASTTM_OFF))
        else $error("active flag out of step");

    a_idle_out: assert property (
        @(posedge clk_i) disable iff (rst_i)
        idle_ph_q == (st_q == asttm_pkg::ASTTM_IDLE))
        else $error("idle flag out of step");

    a_disengage: assert property (
        @(posedge clk_i) disable iff (rst_i)
        axis_sel_q == 2'h0 |=> st_q == asttm_pkg::ASTTM_OFF)
        else $error("self-test not disengaged");

    a_user_back: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_d == asttm_pkg::ASTTM_OFF
        |=> odr_q == $past(user_output_data_rate_i)
        && pm_q == $past(user_power_mode_i))
        else $error("user rate not restored");

    a_codes_held: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_q == asttm_pkg::ASTTM_IDLE && !done_d && axis_sel_q != 2'h0
        |=> $stable(run_idle_q) && $stable(run_dec_q))
        else $error("codes changed mid sequence");

    a_start_latch: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_q == asttm_pkg::ASTTM_OFF && axis_sel_q != 2'h0
        |=> run_idle_q == $past(idle_code_q)
        && run_dec_q == $past(dec_code_q))
        else $error("codes not taken at start");

    a_period_step: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_q |-> cyc_q == 16'h0000 && smp_q == 13'h0000)
        else $error("period counters not reset");

    a_done_pulse: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_q |=> !done_q)
        else $error("period strobe too long");

    a_ack_answer: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !ack_q |=> ack_q)
        else $error("bus request not answered");

    a_ack_pulse: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_q |=> !ack_q)
        else $error("ack held too long");

    // Every register is at most one byte wide, so the upper read lanes stay zero.
    a_read_upper: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_q |-> dat_q[31:8] == 24'h000000)
        else $error("upper read lanes not zero");

    a_read_unmapped: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_q && $past(wb_adr_i) > `ASTTM_STATUS_ADDR
        |-> dat_q == 32'h00000000)
        else $error("unmapped read not zero");
endmodule // asttm_top
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking testbench for the self-test timing block.
`timescale 1ns/100ps
`default_nettype none
`include "asttm_params.svh"
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] rd;
    logic wb_ack_o;
    logic [1:0] user_rate = 2'h0;
    logic user_mode = 1'b0;
    logic [1:0] eff_rate;
    logic eff_mode;
    logic active;
    logic idle_ph;
    logic meas_done;
    int fails = 0;
    int n_compared = 0;
    int mdl [int];
    int c;
    always #20 clk_i = ~clk_i;
    asttm_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .user_output_data_rate_i(user_rate),
        .user_power_mode_i(user_mode), .eff_output_data_rate_o(eff_rate),
        .eff_power_mode_o(eff_mode), .selftest_active_o(active),
        .idle_phase_o(idle_ph), .meas_done_o(meas_done));
    task automatic chk(input logic [31:0] g, input logic [31:0] x,
        input string m);
        n_compared++;
        if (g !== x) begin
            fails++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, m, g, x);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        chk(n < 50, 1, "bus answer");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Counts cycles between two strobes; the first wait only finds a boundary.
    task automatic meas(input int n);
        for (int k = 0; k < n; k++) begin
            c = 0;
            do begin
                @(posedge clk_i);
                c++;
            end while (meas_done !== 1'b1 && c < 40000);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_i);
        fails++;
        give_verdict();
    end
    initial begin
        c = $urandom(49920);
        mdl[8'h37] = 0;
        mdl[8'h38] = 0;
        mdl[8'h3B] = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (mdl[a]) begin
            wb(1'b0, a[7:0], 8'h00);
            chk(rd, mdl[a], "reset value");
            c = $urandom_range(0, 255);
            wb(1'b1, a[7:0], c[7:0]);
            if (a != 8'h3B) mdl[a] = c & ((a == 8'h37) ? 8'h1F : 8'h0F);
            wb(1'b0, a[7:0], 8'h00);
            chk(rd, mdl[a], "read back");
        end
        $display("register test done");
        // Small codes only: the widest decimation runs far too long here.
        for (int i = 0; i < 2; i++) begin
            user_rate <= 2'($urandom_range(1, 3));
            user_mode <= 1'b1;
            wb(1'b1, 8'h37, 8'(i));
            wb(1'b1, 8'h38, 8'(i));
            wb(1'b1, 8'h39, 8'(i + 1));
            meas(2);
            chk(c, (1 << i) * (`ASTTM_IDLE_BASE_CYC + `ASTTM_IDLE_STEP_CYC * i),
                "period");
            // A write in mid-period must not stretch the running period.
            fork
                meas(1);
                wb(1'b1, 8'h37, 8'h1F);
            join
            chk(c, (1 << i) * (`ASTTM_IDLE_BASE_CYC + `ASTTM_IDLE_STEP_CYC * i),
                "codes held");
            wb(1'b0, 8'h3A, 8'h00);
            chk(rd, (i << 4) | 3, "status");
            chk({eff_rate, eff_mode, active, idle_ph}, 5'h03,
                "forced mode");
            wb(1'b1, 8'h39, 8'h00);
            repeat (2) @(posedge clk_i);
            chk({eff_rate, eff_mode, active, idle_ph},
                {user_rate, user_mode, 2'b00}, "user mode back");
            $display("self-test run %0d done", i);
        end
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
